//--- tb/mss_axi_master.sv
// Bus master model standing in for the network master's user program
`timescale 1ns/10ps
`default_nettype none
module mss_axi_master (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [7:0]       awaddr,
  output logic             awvalid, wvalid, bready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        awready, wready, bvalid,
  input  wire logic [1:0]  bresp,
  // Read channels
  output logic [7:0]       araddr,
  output logic             arvalid, rready,
  input  wire logic        arready, rvalid,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  initial
  begin
    awaddr = 8'h00; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    wdata = 32'h0; wstrb = 4'hf; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
  end

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/mss_top_asserts.sv
// Concurrent checks on the ports of the motor starter I/O block
`timescale 1ns/10ps
`default_nettype none
module mss_top_asserts (
  // Clock, reset and bus handshakes
  input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Field inputs and status outputs
  input wire logic        aux_input_one, aux_input_one_status, current_sense,
  input wire logic        current_flow_bit, manual_switch_req, supply_dip, device_fault,
  input wire logic        trip_event, trip_mode_local, motor_forward, motor_reverse,
  input wire logic        ready_status_bit
);
  logic [3:0] up_cnt;
  logic       up;

  // ----------------------------------------
  // Settling window
  // ----------------------------------------
  // Inputs cross a synchroniser, so the field-input checks are not judged until it has flushed
  always_ff @(posedge aclk)
    if (!aresetn)
      up_cnt <= 4'h0;
    else if (up_cnt != 4'hf)
      up_cnt <= up_cnt + 4'h1;
  assign up = (up_cnt == 4'hf);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_wait; s_axi_rvalid && !s_axi_rready; endsequence
  sequence wr_wait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence both_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence held(c); (up && c)[*8]; endsequence
  property not_ready(c); held(c) |-> !ready_status_bit; endproperty

  rd_hold_a: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before taken");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while answer pending");
  wr_hold_a: assert property (wr_wait |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  wr_answer_a: assert property (both_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  aux_mirror_a: assert property (held($stable(aux_input_one)) |-> aux_input_one_status == aux_input_one)
    else $error("aux status does not follow input");
  flow_bit_a: assert property (held($stable(current_sense)) |-> current_flow_bit == current_sense)
    else $error("flow bit does not follow current");
  manual_ready_a: assert property (not_ready(manual_switch_req))
    else $error("ready high in manual");
  dip_ready_a: assert property (not_ready(supply_dip))
    else $error("ready high during supply dip");
  device_ready_a: assert property (not_ready(device_fault))
    else $error("ready high during device fault");
  trip_ready_a: assert property (not_ready(trip_event))
    else $error("ready high while tripped");
  local_trip_a: assert property (held(trip_event && trip_mode_local) |-> !motor_forward && !motor_reverse)
    else $error("motor runs after local trip");
  dir_excl_a: assert property (!(motor_forward && motor_reverse))
    else $error("both directions driven");
endmodule

bind mss_top mss_top_asserts u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .aux_input_one, .aux_input_one_status, .current_sense,
  .current_flow_bit, .manual_switch_req, .supply_dip, .device_fault, .trip_event,
  .trip_mode_local, .motor_forward, .motor_reverse, .ready_status_bit
);
`default_nettype wire

//--- tb/test_motor_starter_bus_io_map.sv
// Self-checking bench for the motor starter I/O block
`timescale 1ns/10ps
`default_nettype none
module test_motor_starter_bus_io_map;
  import mss_pkg::*;
  logic        aclk, aresetn, aux1, aux2, flow, loc, auto_req;
  logic [5:0]  ev;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        fwd, rev, brake, brake_nb, ready, flow_bit, aux1_st, aux2_st;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  mss_top uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .aux_input_one(aux1), .aux_input_two(aux2), .current_sense(flow),
    .manual_switch_req(ev[0]), .handheld_auto_req(auto_req), .trip_event(ev[5]),
    .trip_mode_local(loc), .supply_dip(ev[1]), .unbalance_exceeded(ev[2]),
    .main_circuit_fault(ev[3]), .device_fault(ev[4]), .motor_forward(fwd),
    .motor_reverse(rev), .brake_contact(brake), .ready_status_bit(ready),
    .current_flow_bit(flow_bit), .aux_input_one_status(aux1_st),
    .aux_input_two_status(aux2_st)
  );

  // Variant without brake contact, sharing every input with uut
  mss_top #(.HAS_BRAKE(1'b0)) uut_nb (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
    .aux_input_one(aux1), .aux_input_two(aux2), .current_sense(flow),
    .manual_switch_req(ev[0]), .handheld_auto_req(auto_req), .trip_event(ev[5]),
    .trip_mode_local(loc), .supply_dip(ev[1]), .unbalance_exceeded(ev[2]),
    .main_circuit_fault(ev[3]), .device_fault(ev[4]), .motor_forward(),
    .motor_reverse(), .brake_contact(brake_nb), .ready_status_bit(),
    .current_flow_bit(), .aux_input_one_status(), .aux_input_two_status()
  );

  mss_axi_master m_axi (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .wvalid(wvalid), .bready(bready),
    .wdata(wdata), .wstrb(wstrb), .awready(awready), .wready(wready), .bvalid(bvalid),
    .bresp(bresp), .araddr(araddr), .arvalid(arvalid), .rready(rready), .arready(arready),
    .rvalid(rvalid), .rdata(rdata), .rresp(rresp)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic final_report;
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_pin(input logic g, input logic e);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk,
                         input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    m_axi.rd(a, d, r);
    checked++;
    if ((d & mk) !== e || r !== er)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h/%h expected %h/%h", $time, d & mk, r, e, er);
    end
  endtask

  task automatic chk_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    m_axi.wr(a, d, r);
    checked++;
    if (r !== er)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, r, er);
    end
  endtask

  // Covers the synchroniser and filter with margin
  task automatic settle;
    repeat (10) @(posedge aclk);
  endtask

  // Remote reset pulse around the given run command
  task automatic clr(input logic [3:0] c);
    settle;
    chk_wr(MSS_REG_CMD, {28'h0, c} | 32'h8, MSS_RESP_OKAY);
    chk_wr(MSS_REG_CMD, {28'h0, c}, MSS_RESP_OKAY);
    settle;
  endtask

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      final_report;
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    aresetn = 1'b0; ev = 6'h00; aux1 = 1'b0; aux2 = 1'b0;
    flow = 1'b0; loc = 1'b0; auto_req = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_reg(MSS_REG_ID, MSS_ID_VALUE, 32'hffffffff, MSS_RESP_OKAY);
    chk_reg(MSS_REG_CTRL, 32'h1, 32'h1, MSS_RESP_OKAY);
    chk_reg(8'h14, 32'h0, 32'hffffffff, MSS_RESP_SLVERR);
    chk_wr(8'h14, 32'h0, MSS_RESP_SLVERR);
    for (int i = 0; i < 4; i++)
    begin
      aux1 <= i[0];
      aux2 <= i[1];
      settle;
      chk_pin(aux1_st, i[0]);
      chk_pin(aux2_st, i[1]);
      chk_reg(MSS_REG_STATUS, 32'(i) << MSS_ST_AUX1, 32'h3 << MSS_ST_AUX1, MSS_RESP_OKAY);
    end
    chk_reg(MSS_REG_STATUS, 32'h1, 32'h73, MSS_RESP_OKAY);
    chk_wr(MSS_REG_CMD, 32'h4, MSS_RESP_OKAY);
    settle;
    chk_pin(brake, 1'b1);
    chk_pin(brake_nb, 1'b0);
    chk_pin(fwd, 1'b0);
    flow <= 1'b1;
    chk_wr(MSS_REG_CMD, 32'h1, MSS_RESP_OKAY);
    settle;
    chk_pin(brake, 1'b0);
    chk_pin(fwd, 1'b1);
    chk_pin(flow_bit, 1'b1);
    chk_pin(ready, 1'b1);
    chk_wr(MSS_REG_CMD, 32'h3, MSS_RESP_OKAY);
    settle;
    chk_pin(fwd | rev, 1'b0);
    chk_wr(MSS_REG_CMD, 32'h2, MSS_RESP_OKAY);
    settle;
    chk_pin(rev, 1'b1);
    flow <= 1'b0;
    settle;
    chk_pin(flow_bit, 1'b0);
    chk_pin(ready, 1'b0);
    chk_reg(MSS_REG_FAULT, 32'h1, 32'h1f, MSS_RESP_OKAY);
    flow <= 1'b1;
    clr(4'h2);
    chk_pin(ready, 1'b1);
    ev <= 6'h20;
    settle;
    chk_pin(ready, 1'b0);
    chk_pin(rev, 1'b1);
    chk_reg(MSS_REG_STATUS, 32'h20, 32'h21, MSS_RESP_OKAY);
    ev <= 6'h00;
    loc <= 1'b1;
    clr(4'h2);
    ev <= 6'h20;
    settle;
    chk_pin(rev, 1'b0);
    chk_pin(ready, 1'b0);
    ev <= 6'h00;
    flow <= 1'b0;
    clr(4'h0);
    for (int k = 0; k < 5; k++)
    begin
      ev <= 6'h01 << k;
      settle;
      chk_pin(ready, 1'b0);
      chk_reg(MSS_REG_STATUS, (k == 0) ? 32'h10 : 32'h40, 32'h51, MSS_RESP_OKAY);
      chk_reg(MSS_REG_FAULT, 32'(k != 0) << k, 32'h1f, MSS_RESP_OKAY);
      clr(4'h0);
      chk_pin(ready, 1'b0);
      ev <= 6'h00;
      settle;
      chk_pin(ready, 1'b0);
      auto_req <= 1'b1;
      settle;
      auto_req <= 1'b0;
      clr(4'h0);
      chk_pin(ready, 1'b1);
    end
    final_report;
  end
endmodule
`default_nettype wire

//--- verilog/mss_pkg.sv
// Package: register map, field positions and constants of the motor starter I/O block
package mss_pkg;

  // Register byte offsets (AXI4-Lite, one aligned word each)
  localparam logic [7:0] MSS_REG_CMD      = 8'h00;
  localparam logic [7:0] MSS_REG_STATUS   = 8'h04;
  localparam logic [7:0] MSS_REG_FAULT    = 8'h08;
  localparam logic [7:0] MSS_REG_CTRL     = 8'h0c;
  localparam logic [7:0] MSS_REG_ID       = 8'h10;

  // Command register fields
  localparam int MSS_CMD_FWD   = 0;
  localparam int MSS_CMD_REV   = 1;
  localparam int MSS_CMD_BRAKE = 2;
  localparam int MSS_CMD_RESET = 3;
  localparam int MSS_CMD_W     = 4;

  // Status register fields
  localparam int MSS_ST_READY  = 0;
  localparam int MSS_ST_FLOW   = 1;
  localparam int MSS_ST_AUX1   = 2;
  localparam int MSS_ST_AUX2   = 3;
  localparam int MSS_ST_MANUAL = 4;
  localparam int MSS_ST_TRIP   = 5;
  localparam int MSS_ST_FAULT  = 6;

  // Fault register fields (sticky, cleared by remote reset once cause is gone)
  localparam int MSS_F_NOFLOW  = 0;
  localparam int MSS_F_UNDERV  = 1;
  localparam int MSS_F_UNBAL   = 2;
  localparam int MSS_F_MAIN    = 3;
  localparam int MSS_F_DEVICE  = 4;
  localparam int MSS_F_W       = 5;

  // Control register fields
  localparam int MSS_CTRL_BRAKE = 0;

  // Supply dip threshold, reported by the analog comparator
  localparam int MSS_UNDERV_MV = 18000;

  // Identification value, arbitrary
  localparam logic [31:0] MSS_ID_VALUE = 32'h0000_a5c3;

  localparam logic [1:0] MSS_RESP_OKAY   = 2'b00;
  localparam logic [1:0] MSS_RESP_SLVERR = 2'b10;

  localparam logic [MSS_CMD_W-1:0] MSS_CMD_RST = 4'h0;
  localparam logic [MSS_F_W-1:0]   MSS_F_RST   = 5'h00;

  typedef enum logic [1:0] {MSS_AUTO, MSS_MANUAL} mss_mode_t;

endpackage

//--- verilog/mss_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module mss_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } mss_sync_state_t;

  mss_sync_state_t st;
  mss_sync_state_t next_st;

  always_comb
  begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Change accepted only once stages two and three agree
    for (int i = 0; i < W; i++)
    begin
      if (st.s2[i] == st.s3[i])
      begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign q = st.q;

endmodule
`default_nettype wire

//--- verilog/mss_top.sv
// Top: AXI4-Lite slave and command/status logic of the solid-state reversing starter
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [R1] Brake driven only when brake contact fitted
// [R2] Brake follows own bit, independent of run
// [R3] Program coordinates brake and run safely
// [R4] Manual clears ready; hand unit restores auto
// [R5] Local trip: motor off, ready cleared
// [R6] Remote trip: ready cleared, program decides
// [R7] No current flow fault clears ready
// [R8] Supply dip below 18 V faults
// [R9] Current unbalance over limit faults
// [R10] Main circuit fault clears ready
// [R11] Device fault latched until reset after removal
// [R12] Program checks ready before relying on commands
// [R13] Current flow bit is 1 when flowing
// [R14] Aux status bits mirror aux inputs
// [R15] Command bits: 1 on, 0 off
module mss_top
  import mss_pkg::*;
#(
  parameter bit HAS_BRAKE = 1'b1
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Local field inputs (asynchronous)
  input  wire logic        aux_input_one,
  input  wire logic        aux_input_two,
  input  wire logic        current_sense,
  input  wire logic        manual_switch_req,
  input  wire logic        handheld_auto_req,
  input  wire logic        trip_event,
  input  wire logic        trip_mode_local,
  input  wire logic        supply_dip,
  input  wire logic        unbalance_exceeded,
  input  wire logic        main_circuit_fault,
  input  wire logic        device_fault,
  // Power stage outputs
  output logic             motor_forward,
  output logic             motor_reverse,
  output logic             brake_contact,
  // Bus status bits
  output logic             ready_status_bit,
  output logic             current_flow_bit,
  output logic             aux_input_one_status,
  output logic             aux_input_two_status
);

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  localparam int NIN = 11;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] syn;

  assign raw_in = {device_fault, main_circuit_fault, unbalance_exceeded, supply_dip,
                   trip_mode_local, trip_event, handheld_auto_req, manual_switch_req,
                   current_sense, aux_input_two, aux_input_one};

  mss_sync #(.W(NIN)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (raw_in),
    .q       (syn)
  );

  logic aux1_s, aux2_s, flow_s, man_s, auto_s, trip_s, tloc_s;
  logic dip_s, unb_s, mainf_s, devf_s;
  assign {devf_s, mainf_s, unb_s, dip_s, tloc_s, trip_s, auto_s, man_s,
          flow_s, aux2_s, aux1_s} = syn;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic                 aw_held;
    logic                 w_held;
    logic [7:0]           awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [MSS_CMD_W-1:0] cmd;
    mss_mode_t            mode;
    logic                 tripped;
    logic                 trip_prev;
    logic                 trip_cut;
    logic [MSS_F_W-1:0]   fault;
    logic                 fwd;
    logic                 rev;
    logic                 brake;
    logic                 ready;
    logic                 flow;
    logic                 aux1;
    logic                 aux2;
  } mss_state_t;

  mss_state_t st;
  mss_state_t next_st;

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [MSS_F_W-1:0] fault_src;
  logic [31:0]        status_word;
  logic [31:0]        ctrl_word;

  always_comb
  begin
    fault_src                = '0;
    fault_src[MSS_F_NOFLOW]  = (st.fwd | st.rev) & ~flow_s; // [R7]
    fault_src[MSS_F_UNDERV]  = dip_s;   // [R8]
    fault_src[MSS_F_UNBAL]   = unb_s;   // [R9]
    fault_src[MSS_F_MAIN]    = mainf_s; // [R10]
    fault_src[MSS_F_DEVICE]  = devf_s;  // [R11]
    status_word                 = '0;
    status_word[MSS_ST_READY]   = st.ready;
    status_word[MSS_ST_FLOW]    = st.flow;
    status_word[MSS_ST_AUX1]    = st.aux1;
    status_word[MSS_ST_AUX2]    = st.aux2;
    status_word[MSS_ST_MANUAL]  = (st.mode == MSS_MANUAL);
    status_word[MSS_ST_TRIP]    = st.tripped;
    status_word[MSS_ST_FAULT]   = |st.fault;
    ctrl_word    = '0;
    ctrl_word[MSS_CTRL_BRAKE] = HAS_BRAKE; // [R1]
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Full-width scratch for the strobe merge; only the command bits are kept
  logic [31:0] cmd_merged;
  logic        rst_cmd;

  always_comb
  begin
    next_st    = st;
    cmd_merged = '0;
    rst_cmd    = st.cmd[MSS_CMD_RESET]; // [R15]

    // Write channel capture, either order
    if (st.awready && s_axi_awvalid)
    begin
      next_st.awaddr  = s_axi_awaddr;
      next_st.aw_held = 1'b1;
      next_st.awready = 1'b0;
    end
    if (st.wready && s_axi_wvalid)
    begin
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
      next_st.w_held = 1'b1;
      next_st.wready = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = MSS_RESP_OKAY;
      // Byte strobes only matter for the command word
      case (st.awaddr)
        MSS_REG_CMD:
        begin
          cmd_merged  = merge_strb({28'h0000000, st.cmd}, st.wdata, st.wstrb);
          next_st.cmd = cmd_merged[MSS_CMD_W-1:0];
        end
        MSS_REG_STATUS, MSS_REG_FAULT, MSS_REG_CTRL, MSS_REG_ID:
        begin
          next_st.bresp = MSS_RESP_OKAY;
        end
        default:
        begin
          next_st.bresp = MSS_RESP_SLVERR;
        end
      endcase
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // Read channel
    // A new address waits until the pending answer is taken
    if (s_axi_arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = MSS_RESP_OKAY;
      case (s_axi_araddr)
        MSS_REG_CMD:    next_st.rdata = {28'h0000000, st.cmd};
        MSS_REG_STATUS: next_st.rdata = status_word;
        MSS_REG_FAULT:  next_st.rdata = {27'h0000000, st.fault};
        MSS_REG_CTRL:   next_st.rdata = ctrl_word;
        MSS_REG_ID:     next_st.rdata = MSS_ID_VALUE;
        default:
        begin
          next_st.rdata = '0;
          next_st.rresp = MSS_RESP_SLVERR;
        end
      endcase
    end
    else if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end

    // Manual / automatic mode
    case (st.mode)
      MSS_AUTO:
      begin
        if (man_s)
        begin
          next_st.mode = MSS_MANUAL; // [R4]
        end
      end
      MSS_MANUAL:
      begin
        // Only the hand-held unit brings the starter back
        if (auto_s && !man_s)
        begin
          next_st.mode = MSS_AUTO; // [R4]
        end
      end
      default:
      begin
        next_st.mode = MSS_AUTO;
      end
    endcase

    // Trip latch; rising edge sets, remote reset clears once cause gone
    next_st.trip_prev = trip_s;
    if (rst_cmd && !trip_s)
    begin
      next_st.tripped  = 1'b0;
      next_st.trip_cut = 1'b0;
    end
    if (trip_s && !st.trip_prev)
    begin
      next_st.tripped = 1'b1;       // [R6]
      if (tloc_s)
      begin
        next_st.trip_cut = 1'b1;    // [R5]
      end
    end

    // Faults: sticky; reset only removes bits whose cause is gone; set wins
    if (rst_cmd)
    begin
      next_st.fault = st.fault & fault_src; // [R11]
    end
    next_st.fault = next_st.fault | fault_src; // [R7] [R8] [R9] [R10]

    // Power stage; interlock both directions, local trip cuts motor
    next_st.fwd = st.cmd[MSS_CMD_FWD] & ~st.cmd[MSS_CMD_REV] & ~st.trip_cut // [R15] [R5]
                  & (st.mode == MSS_AUTO);
    next_st.rev = st.cmd[MSS_CMD_REV] & ~st.cmd[MSS_CMD_FWD] & ~st.trip_cut // [R15] [R5]
                  & (st.mode == MSS_AUTO);
    // Brake from its own bit only; run commands and trips do not touch it
    next_st.brake = HAS_BRAKE & st.cmd[MSS_CMD_BRAKE]; // [R1] [R2]

    next_st.ready = (st.mode == MSS_AUTO) & ~st.tripped & ~(|st.fault); // [R4] [R6] [R11]
    next_st.flow  = flow_s; // [R13]
    next_st.aux1  = aux1_s; // [R14]
    next_st.aux2  = aux2_s; // [R14]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st         <= '0;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.mode    <= MSS_AUTO;
      st.cmd     <= MSS_CMD_RST;
      st.fault   <= MSS_F_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready        = st.awready;
  assign s_axi_wready         = st.wready;
  assign s_axi_bvalid         = st.bvalid;
  assign s_axi_bresp          = st.bresp;
  assign s_axi_arready        = ~st.rvalid;
  assign s_axi_rvalid         = st.rvalid;
  assign s_axi_rdata          = st.rdata;
  assign s_axi_rresp          = st.rresp;
  assign motor_forward        = st.fwd;
  assign motor_reverse        = st.rev;
  assign brake_contact        = st.brake;
  assign ready_status_bit     = st.ready;
  assign current_flow_bit     = st.flow;
  assign aux_input_one_status = st.aux1;
  assign aux_input_two_status = st.aux2;

endmodule
`default_nettype wire
